// file: inc/csw_defs.svh
// Offsets, field positions, reset values and codes of the chip-select block
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH
`define CSW_OFF_BASE0     8'h00
`define CSW_OFF_OPTION0   8'h10
`define CSW_OFF_CONTROL   8'h20
`define CSW_OFF_STATUS    8'h24
`define CSW_LINES         4
`define CSW_FC_HI         15
`define CSW_FC_LO         13
`define CSW_ADDR_HI       12
`define CSW_ADDR_LO       2
`define CSW_DIR_BIT       1
`define CSW_EN_BIT        0
`define CSW_CMP_SPACE_BIT 0
`define CSW_FC_RESERVED   3'h7
`define CSW_TERM_EXTERNAL 3'h7
`define CSW_BASE0_RESET   16'hc001
`define CSW_BASE_RESET    16'hc000
`define CSW_OPTION_RESET  16'hdffd
`define CSW_CTL_CONFLICT  0
`define CSW_CTL_WPROT     1
`define CSW_CTL_LOCKED    2
`define CSW_CTL_EXTWAIT   3
`define CSW_STS_CONFLICT  0
`define CSW_STS_WPROT     1
`endif

// file: inc/csw_pkg.sv
// Types shared by the chip-select and wait-state block
package csw_pkg;
  typedef enum logic [2:0] {
    CSW_IDLE = 3'b001,
    CSW_WAIT = 3'b010,
    CSW_HOLD = 3'b100
  } csw_state_type;

  typedef struct packed {
    logic        as_n;
    logic [10:0] addr;
    logic [2:0]  fc;
    logic        read;
    logic        ext_master;
    logic        iack;
    logic        locked_write;
    logic        internal;
  } csw_bus_type;

  typedef struct packed {
    csw_bus_type        sync1;
    csw_bus_type        sync2;
    csw_bus_type        sync3;
    csw_bus_type        stable;
    logic [3:0][15:0]   base;
    logic [3:0][15:0]   option;
    logic [3:0]         control;
    logic               conflict_flag;
    logic               write_protect_flag;
    logic               strap_done;
    csw_state_type      fsm;
    logic [2:0]         wait_cnt;
    logic [3:0]         select_n;
    logic               dtack_n;
    logic               berr_n;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } csw_regs_type;
endpackage : csw_pkg

// file: core/csw_top.sv
// Chip-select decoder with wait-state termination and APB register file
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "csw_defs.svh"

// What this block does
// - Four select lines, identical decode, each with own termination.
// - Both master kinds decoded; line asserts on strobe fall.
// - Termination is produced only when that block's line asserts.
// - After reset line 0 covers 0 to 8K with six wait states.
// - On-chip accesses select nothing; otherwise line 0 beats 1, 2, 3.
// - Multiple matches: conflict flag, bus error if enabled, one line.
// - Configuration register writes never raise bus error.
// - Read-only against write-only overlap is no conflict.
// - Write to read-only block: protect flag, maybe bus error, no line.
// - Only total system reset restores configuration defaults.
// - On-chip RAM and register accesses activate no line.
// - No match during interrupt acknowledge cycles.
// - Locked write portion waits only when locked-wait enable set, or when its block uses external termination (111).
// - Base register: code 15-13, address 12-2, direction 1, enable 0.
// - Space code 111 in a block never asserts its line.
// - Reset base: code 110, address zero, read-only; only line 0 on.
// - Direction bit limits to reads or writes unless option masks it.
// - Parameters change while enabled without disabling first.
// - Extra wait for internally ended external-master cycles when set.
// - Space code compare optional; address bits maskable per option.
// - Option 15-13 gives 0 to 6 waits; 111 means external termination.
// - Mask bit 0 excludes address bit, 1 includes; reset all ones.
// - Zero waits terminate at once; else waits counted on clock.
module csw_top #(
  parameter int ADDR_W = 8
) (
  // Clock and total system reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  // Processor bus, asynchronous pins
  input  wire logic              as_n,
  input  wire logic [10:0]       addr_hi,
  input  wire logic [2:0]        space_code,
  input  wire logic              read,
  input  wire logic              ext_master,
  input  wire logic              iack,
  input  wire logic              locked_write,
  input  wire logic              internal_access_indicator,
  // Strap sampled once after reset release
  input  wire logic              disable_core,
  // Selects and termination
  output logic                   select_line_0_n,
  output logic                   select_line_1_n,
  output logic                   select_line_2_n,
  output logic                   select_line_3_n,
  output logic                   dtack_n,
  output logic                   berr_n
);

  csw_pkg::csw_regs_type r;
  csw_pkg::csw_regs_type next_r;
  csw_pkg::csw_bus_type  pins;
  csw_pkg::csw_bus_type  bus;

  logic [3:0]  hit_any;
  logic [3:0]  match;
  logic [3:0]  wp_hit;
  logic        conflict;
  logic        active;
  logic        zero_wait;
  logic [1:0]  winner;
  logic [2:0]  waits;
  logic [2:0]  code;
  logic        excluded;
  logic        wr_take;
  logic [ADDR_W-1:0] off;

  assign pins.as_n         = as_n;
  assign pins.addr         = addr_hi;
  assign pins.fc           = space_code;
  assign pins.read         = read;
  assign pins.ext_master   = ext_master;
  assign pins.iack         = iack;
  assign pins.locked_write = locked_write;
  assign pins.internal     = internal_access_indicator;

  assign bus    = r.stable;
  assign active = ~bus.as_n;
  assign off    = paddr;

  // Per-line compare on settled pin values
  always_comb begin
    excluded = bus.internal | bus.iack;
    for (int i = 0; i < `CSW_LINES; i++) begin
      hit_any[i] = r.base[i][`CSW_EN_BIT]
        & (~r.option[i][`CSW_CMP_SPACE_BIT]
           | (bus.fc == r.base[i][`CSW_FC_HI:`CSW_FC_LO]))
        & (bus.fc != `CSW_FC_RESERVED)
        & (r.base[i][`CSW_FC_HI:`CSW_FC_LO] != `CSW_FC_RESERVED)
        & (((bus.addr ^ r.base[i][`CSW_ADDR_HI:`CSW_ADDR_LO])
            & r.option[i][`CSW_ADDR_HI:`CSW_ADDR_LO]) == 11'h000)
        & ~excluded;
      match[i] = hit_any[i]
        & (~r.option[i][`CSW_DIR_BIT]
           | (r.base[i][`CSW_DIR_BIT] == ~bus.read));
      wp_hit[i] = hit_any[i] & r.option[i][`CSW_DIR_BIT]
        & ~r.base[i][`CSW_DIR_BIT] & ~bus.read;
    end
  end

  // Direction-qualified matches keep read-only/write-only pairs apart
  assign conflict = (match & (match - 4'h1)) != 4'h0;

  always_comb begin
    winner = 2'h3;
    for (int i = `CSW_LINES - 1; i >= 0; i--) begin
      if (match[i]) begin
        winner = 2'(i);
      end
    end
  end

  always_comb begin
    code  = r.option[winner][`CSW_FC_HI:`CSW_FC_LO];
    waits = code;
    if (bus.ext_master && r.control[`CSW_CTL_EXTWAIT]) begin
      waits = code + 3'h1;
    end
    if (bus.locked_write && !r.control[`CSW_CTL_LOCKED]) begin
      waits = 3'h0;
    end
    zero_wait = (waits == 3'h0);
  end

  assign wr_take = psel & penable & r.pready & pwrite;

  always_comb begin
    next_r = r;
    // Three-stage synchroniser; value moves when stages two and three agree
    next_r.sync1  = pins;
    next_r.sync2  = r.sync1;
    next_r.sync3  = r.sync2;
    next_r.stable = (r.sync2 & r.sync3) | (r.stable & (r.sync2 ^ r.sync3));

    // Strap is static, so one look after release is enough
    if (!r.strap_done) begin
      next_r.strap_done = 1'b1;
      if (disable_core) begin
        for (int i = 0; i < `CSW_LINES; i++) begin
          next_r.base[i][`CSW_EN_BIT] = 1'b0;
        end
      end
    end

    // APB: one wait-free access phase, answered by a registered pready
    next_r.pready  = psel & ~penable & ~r.pready;
    next_r.pslverr = 1'b0;
    if (psel && !penable && !r.pready) begin
      next_r.prdata  = 32'h0000_0000;
      next_r.pslverr = 1'b1;
      for (int i = 0; i < `CSW_LINES; i++) begin
        if (off == ADDR_W'(`CSW_OFF_BASE0 + 4 * i)) begin
          next_r.prdata  = {16'h0000, r.base[i]};
          next_r.pslverr = 1'b0;
        end
        if (off == ADDR_W'(`CSW_OFF_OPTION0 + 4 * i)) begin
          next_r.prdata  = {16'h0000, r.option[i]};
          next_r.pslverr = 1'b0;
        end
      end
      if (off == ADDR_W'(`CSW_OFF_CONTROL)) begin
        next_r.prdata  = {28'h000_0000, r.control};
        next_r.pslverr = 1'b0;
      end
      if (off == ADDR_W'(`CSW_OFF_STATUS)) begin
        next_r.prdata  = {27'h000_0000, r.fsm, r.write_protect_flag,
                          r.conflict_flag};
        next_r.pslverr = 1'b0;
      end
    end

    // Writes land at once, even on an enabled line; never a bus error
    if (wr_take) begin
      for (int i = 0; i < `CSW_LINES; i++) begin
        if (off == ADDR_W'(`CSW_OFF_BASE0 + 4 * i)) begin
          next_r.base[i] = pwdata[15:0];
        end
        if (off == ADDR_W'(`CSW_OFF_OPTION0 + 4 * i)) begin
          next_r.option[i] = pwdata[15:0];
        end
      end
      if (off == ADDR_W'(`CSW_OFF_CONTROL)) begin
        next_r.control = pwdata[3:0];
      end
      if (off == ADDR_W'(`CSW_OFF_STATUS)) begin
        if (pwdata[`CSW_STS_CONFLICT]) begin
          next_r.conflict_flag = 1'b0;
        end
        if (pwdata[`CSW_STS_WPROT]) begin
          next_r.write_protect_flag = 1'b0;
        end
      end
    end

    // Bus cycle sequencer
    unique case (r.fsm)
      csw_pkg::CSW_IDLE: begin
        if (active) begin
          next_r.fsm = csw_pkg::CSW_HOLD;
          if (conflict) begin
            next_r.conflict_flag = 1'b1;
            if (r.control[`CSW_CTL_CONFLICT]) begin
              next_r.berr_n = 1'b0;
            end
          end
          if (wp_hit != 4'h0) begin
            next_r.write_protect_flag = 1'b1;
            if (r.control[`CSW_CTL_WPROT]) begin
              next_r.berr_n = 1'b0;
            end
          end
          if (match != 4'h0) begin
            next_r.select_n[winner] = 1'b0;
            if (code == `CSW_TERM_EXTERNAL) begin
              next_r.fsm = csw_pkg::CSW_HOLD;
            end else if (zero_wait) begin
              next_r.dtack_n = 1'b0;
            end else begin
              next_r.wait_cnt = waits;
              next_r.fsm      = csw_pkg::CSW_WAIT;
            end
          end
        end
      end
      csw_pkg::CSW_WAIT: begin
        if (!active) begin
          next_r.fsm = csw_pkg::CSW_IDLE;
        end else if (r.wait_cnt == 3'h1) begin
          next_r.dtack_n = 1'b0;
          next_r.fsm     = csw_pkg::CSW_HOLD;
        end else begin
          next_r.wait_cnt = r.wait_cnt - 3'h1;
        end
      end
      csw_pkg::CSW_HOLD: begin
        if (!active) begin
          next_r.fsm = csw_pkg::CSW_IDLE;
        end
      end
      default: begin
        next_r.fsm = csw_pkg::CSW_IDLE;
      end
    endcase
    if (r.fsm != csw_pkg::CSW_IDLE && !active) begin
      next_r.select_n = 4'hf;
      next_r.dtack_n  = 1'b1;
      next_r.berr_n   = 1'b1;
      next_r.wait_cnt = 3'h0;
    end
  end

  // Total system reset is the only reset of this state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.sync1              <= '1;
      r.sync2              <= '1;
      r.sync3              <= '1;
      r.stable             <= '1;
      r.base[0]            <= `CSW_BASE0_RESET;
      r.base[1]            <= `CSW_BASE_RESET;
      r.base[2]            <= `CSW_BASE_RESET;
      r.base[3]            <= `CSW_BASE_RESET;
      r.option             <= {4{`CSW_OPTION_RESET}};
      r.control            <= 4'h0;
      r.conflict_flag      <= 1'b0;
      r.write_protect_flag <= 1'b0;
      r.strap_done         <= 1'b0;
      r.fsm                <= csw_pkg::CSW_IDLE;
      r.wait_cnt           <= 3'h0;
      r.select_n           <= 4'hf;
      r.dtack_n            <= 1'b1;
      r.berr_n             <= 1'b1;
      r.pready             <= 1'b0;
      r.pslverr            <= 1'b0;
      r.prdata             <= 32'h0000_0000;
    end else begin
      r <= next_r;
    end
  end

  assign pready          = r.pready;
  assign pslverr         = r.pslverr;
  assign prdata          = r.prdata;
  assign select_line_0_n = r.select_n[0];
  assign select_line_1_n = r.select_n[1];
  assign select_line_2_n = r.select_n[2];
  assign select_line_3_n = r.select_n[3];
  assign dtack_n         = r.dtack_n;
  assign berr_n          = r.berr_n;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic start;
  assign start = (r.fsm == csw_pkg::CSW_IDLE) && active;

  a_single_line: assert property ($onehot0(~r.select_n))
    else $error("more than one select line asserted");
  a_dtack_with_sel: assert property (
    !r.dtack_n |-> r.select_n != 4'hf)
    else $error("termination without a select line");
  a_strobe_release: assert property (
    (r.fsm != csw_pkg::CSW_IDLE) && !active
    |=> r.select_n == 4'hf && r.dtack_n && r.berr_n)
    else $error("outputs not released after strobe negation");
  a_boot_default: assert property (
    !r.strap_done |-> r.base[0] == `CSW_BASE0_RESET
    && r.option[0] == `CSW_OPTION_RESET)
    else $error("line 0 boot default wrong");
  a_onchip_quiet: assert property (
    start && bus.internal |=> r.select_n == 4'hf && r.dtack_n)
    else $error("on-chip access selected a line");
  a_iack_quiet: assert property (
    start && bus.iack |=> r.select_n == 4'hf)
    else $error("interrupt acknowledge selected a line");
  a_fc_reserved: assert property (
    start && bus.fc == `CSW_FC_RESERVED |=> r.select_n == 4'hf)
    else $error("reserved space code selected a line");
  a_zero_wait: assert property (
    start && match != 4'h0 && zero_wait
    && code != `CSW_TERM_EXTERNAL |=> !r.dtack_n)
    else $error("zero wait termination late");
  // Select lands one edge after start, then one edge per wait state
  a_wait_count: assert property (
    start && match != 4'h0 && waits == 3'h2 && code != `CSW_TERM_EXTERNAL
    |=> r.dtack_n ##1 r.dtack_n ##1 (!r.dtack_n || !active))
    else $error("two wait states not counted");
  a_conflict_set: assert property (
    start && conflict |=> r.conflict_flag)
    else $error("conflict flag not set");
  a_protect_block: assert property (
    start && wp_hit != 4'h0 && match == 4'h0
    |=> r.select_n == 4'hf && r.write_protect_flag)
    else $error("protected write not blocked");

  c_zero_wait: cover property (start && zero_wait && match != 4'h0);
  c_waited: cover property (r.fsm == csw_pkg::CSW_WAIT ##1 !r.dtack_n);
  c_conflict: cover property (start && conflict);
  c_protect: cover property (start && wp_hit != 4'h0);

endmodule : csw_top

// file: verification/csw_mem_model.sv
// Model of the memories behind the four chip-select lines
`timescale 1ns/1ps
module csw_mem_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Select lines from the decoder
  input  wire logic [3:0] select_n,
  // Selections seen per line
  output logic [3:0][7:0] hits
);
  logic [3:0] prev_n;

  // A memory only wakes on a fresh falling select edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hits <= 32'h0;
      prev_n <= 4'hf;
    end else begin
      prev_n <= select_n;
      for (int i = 0; i < 4; i++) begin
        if (prev_n[i] && !select_n[i]) begin
          hits[i] <= hits[i] + 8'h01;
        end
      end
    end
  end
endmodule : csw_mem_model

// file: verification/chip_select_wait_state_logic_tb_top.sv
// Bench for the chip-select decoder with wait-state termination
`timescale 1ns/1ps
`include "csw_defs.svh"
module chip_select_wait_state_logic_tb_top;
  logic            pclk;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            as_n = 1'b1;
  logic [10:0]     addr_hi = 11'h000;
  logic [2:0]      space_code = 3'h6;
  logic            read = 1'b1;
  logic            ext_master = 1'b0;
  logic            iack = 1'b0;
  logic            locked_write = 1'b0;
  logic            internal_access = 1'b0;
  logic            disable_core = 1'b0;
  logic            dtack_n;
  logic            berr_n;
  logic [3:0]      sel_n;
  logic [3:0][7:0] hits;
  logic [31:0]     rd;
  logic            err;
  int              fail_count = 0;
  int              cmp_count = 0;

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  csw_top #(.ADDR_W(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .as_n(as_n), .addr_hi(addr_hi),
    .space_code(space_code), .read(read), .ext_master(ext_master),
    .iack(iack), .locked_write(locked_write),
    .internal_access_indicator(internal_access),
    .disable_core(disable_core), .select_line_0_n(sel_n[0]),
    .select_line_1_n(sel_n[1]), .select_line_2_n(sel_n[2]),
    .select_line_3_n(sel_n[3]), .dtack_n(dtack_n), .berr_n(berr_n));

  csw_mem_model mem (.pclk(pclk), .presetn(presetn), .select_n(sel_n),
    .hits(hits));

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task rst(input logic dc);
    @(posedge pclk);
    presetn <= 1'b0;
    disable_core <= dc;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : rst

  // Request held until pready is sampled high at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 20), 32'h1, "apb answer");
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e, "register read");
  endtask : rchk

  // f = {read, ext_master, locked_write, internal, iack}; ew 10 = none
  task bcyc(input logic [10:0] a, input logic [2:0] fc,
            input logic [4:0] f, input logic [3:0] es,
            input logic [31:0] ew, input logic eb);
    int n;
    @(posedge pclk);
    addr_hi <= a;
    space_code <= fc;
    {read, ext_master, locked_write, internal_access, iack} <= f;
    as_n <= 1'b0;
    n = 0;
    while (sel_n === 4'hf && berr_n === 1'b1 && n < 10) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(sel_n), 32'(es), "select lines");
    chk(32'(berr_n), 32'(eb), "bus error");
    n = 0;
    while (dtack_n !== 1'b0 && n < 10) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(n), ew, "wait states");
    @(posedge pclk);
    as_n <= 1'b1;
    repeat (6) @(posedge pclk);
    #1;
    chk(32'({berr_n, dtack_n, sel_n}), 32'h3f, "strobe release");
  endtask : bcyc

  initial begin
    #2000000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    rst(1'b0);
    rchk(`CSW_OFF_BASE0, 32'h0000c001);
    rchk(8'h0c, 32'h0000c000);
    rchk(`CSW_OFF_OPTION0, 32'h0000dffd);
    rchk(`CSW_OFF_CONTROL, 32'h0);
    rchk(`CSW_OFF_STATUS, 32'h4);
    $display("test reset_values done");
    bcyc(11'h000, 3'h6, 5'b10000, 4'he, 32'd6, 1'b1);
    bcyc(11'h000, 3'h6, 5'b00000, 4'he, 32'd6, 1'b1);
    bcyc(11'h000, 3'h6, 5'b10010, 4'hf, 32'd10, 1'b1);
    bcyc(11'h000, 3'h6, 5'b10001, 4'hf, 32'd10, 1'b1);
    bcyc(11'h000, 3'h7, 5'b10000, 4'hf, 32'd10, 1'b1);
    bcyc(11'h001, 3'h6, 5'b10000, 4'hf, 32'd10, 1'b1);
    bcyc(11'h000, 3'h5, 5'b10000, 4'hf, 32'd10, 1'b1);
    $display("test boot_and_refusals done");
    apb(1'b1, `CSW_OFF_OPTION0, 32'h1ffc);
    bcyc(11'h000, 3'h5, 5'b10000, 4'he, 32'd0, 1'b1);
    apb(1'b1, `CSW_OFF_CONTROL, 32'h8);
    bcyc(11'h000, 3'h6, 5'b11000, 4'he, 32'd1, 1'b1);
    apb(1'b1, `CSW_OFF_OPTION0, 32'h5ffc);
    apb(1'b1, `CSW_OFF_CONTROL, 32'h0);
    bcyc(11'h000, 3'h6, 5'b00100, 4'he, 32'd0, 1'b1);
    apb(1'b1, `CSW_OFF_CONTROL, 32'h4);
    bcyc(11'h000, 3'h6, 5'b00100, 4'he, 32'd2, 1'b1);
    $display("test wait_states done");
    apb(1'b1, `CSW_OFF_OPTION0, 32'h5fff);
    apb(1'b1, `CSW_OFF_CONTROL, 32'h2);
    bcyc(11'h000, 3'h6, 5'b00000, 4'hf, 32'd10, 1'b0);
    rchk(`CSW_OFF_STATUS, 32'h6);
    apb(1'b1, `CSW_OFF_STATUS, 32'h2);
    rchk(`CSW_OFF_STATUS, 32'h4);
    $display("test write_protect done");
    // Line 1 overlays the aligned 8K boot block
    apb(1'b1, 8'h04, 32'hc001);
    apb(1'b1, `CSW_OFF_CONTROL, 32'h1);
    chk(32'(berr_n), 32'h1, "config write");
    bcyc(11'h000, 3'h6, 5'b10000, 4'he, 32'd2, 1'b0);
    rchk(`CSW_OFF_STATUS, 32'h5);
    apb(1'b1, `CSW_OFF_STATUS, 32'h1);
    apb(1'b1, 8'h14, 32'hdfff);
    apb(1'b1, 8'h04, 32'hc003);
    bcyc(11'h000, 3'h6, 5'b10000, 4'he, 32'd2, 1'b1);
    rchk(`CSW_OFF_STATUS, 32'h4);
    bcyc(11'h000, 3'h6, 5'b00000, 4'hd, 32'd6, 1'b1);
    rchk(`CSW_OFF_STATUS, 32'h6);
    chk(32'(hits[1]), 32'h1, "line 1 selections");
    // Lines 2 and 3 overlay the boot block once 0 and 1 are off
    apb(1'b1, 8'h08, 32'hc001);
    apb(1'b1, 8'h0c, 32'hc001);
    apb(1'b1, `CSW_OFF_BASE0, 32'hc000);
    apb(1'b1, 8'h04, 32'hc002);
    bcyc(11'h000, 3'h6, 5'b10000, 4'hb, 32'd6, 1'b0);
    rchk(`CSW_OFF_STATUS, 32'h7);
    apb(1'b1, 8'h08, 32'hc000);
    apb(1'b1, 8'h1c, 32'hfffd);
    bcyc(11'h000, 3'h6, 5'b10000, 4'h7, 32'd10, 1'b1);
    chk(32'({hits[3], hits[2]}), 32'h0101, "line 2 3 hits");
    $display("test conflicts done");
    apb(1'b0, 8'h30, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test unmapped done");
    rst(1'b1);
    rchk(`CSW_OFF_BASE0, 32'h0000c000);
    rchk(`CSW_OFF_OPTION0, 32'h0000dffd);
    rchk(`CSW_OFF_STATUS, 32'h4);
    bcyc(11'h000, 3'h6, 5'b10000, 4'hf, 32'd10, 1'b1);
    $display("test disable_core done");
    end_sim();
  end
endmodule : chip_select_wait_state_logic_tb_top
